// File: hireg_pkg.sv
// Purpose: shared constants and carriers for the high-register / PC-relative load decoder
// Assumes: 16-bit compact instructions, 32-bit data path, 16 registers
// Notes: cycle counts mirror the equivalent 32-bit-state instructions
package hireg_pkg;

	// ==========================================================
	// Instruction fields
	localparam int DST_LSB = 0;
	localparam int SRC_LSB = 3;
	localparam int H2_BIT = 6;
	localparam int H1_BIT = 7;
	localparam int OP_LSB = 8;
	localparam int LDR_RD_LSB = 8;
	localparam int LDR_OFF_LSB = 0;
	localparam logic [5:0] FMT5_MATCH = 6'h11;
	localparam logic [4:0] FMT6_MATCH = 5'h09;
	localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
	localparam logic [3:0] PC_REG = 4'hf;

	// ==========================================================
	// Cycle counts (equivalent 32-bit-state costs)
	localparam int ALU_CYCLES = 1;
	localparam int PCW_CYCLES = 3;
	localparam int LDR_CYCLES = 3;

	// ==========================================================
	// Reset values
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic COMPACT_RST = 1'b1;

	typedef enum logic [1:0] {OP_ADD, OP_CMP, OP_MOV, OP_BRX} op_e;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] data;
		logic en;
	} rf_wr_s;

endpackage

// File: hireg_field.sv
// Purpose: field split and register selection for the high-register format
// Assumes: instruction already qualified as the high-register format
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module hireg_field
	import hireg_pkg::*;
(
	// Instruction
	input wire logic [15:0] i_instr,
	// Decoded selects
	output logic [3:0] o_dst_sel,
	output logic [3:0] o_src_sel,
	output op_e o_op,
	output logic o_first_high_operand_flag
);
	always_comb begin
		o_first_high_operand_flag = i_instr[H1_BIT];
		// H1 supplies bit 3 of the dest select, H2 bit 3 of the source select
		o_dst_sel = {i_instr[H1_BIT], i_instr[DST_LSB +: 3]};
		o_src_sel = {i_instr[H2_BIT], i_instr[SRC_LSB +: 3]};
		o_op = op_e'(i_instr[OP_LSB +: 2]);
	end
endmodule
`default_nettype wire

// File: hireg_ops_branch_pc_load_decode.sv
// Purpose: execute high-register ADD/CMP/MOV, register branch and PC-relative load
// Assumes: core holds issue while o_busy is high; register file reads are combinational
// Notes: register file lives outside; this block drives its write port and flags
`timescale 1ns/1ps
`default_nettype none
module hireg_ops_branch_pc_load_decode
	import hireg_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Issue
	input wire logic i_issue,
	input wire logic [15:0] i_instr,
	input wire logic [31:0] i_instr_addr,
	// Register file read data
	output logic [3:0] o_rd_a_sel,
	output logic [3:0] o_rd_b_sel,
	input wire logic [31:0] i_rd_a_data,
	input wire logic [31:0] i_rd_b_data,
	// Memory load return
	input wire logic i_load_valid,
	input wire logic [31:0] i_load_data,
	// Results
	output rf_wr_s o_rf_wr,
	output flags_s o_flags,
	output logic o_flags_we,
	output logic o_branch,
	output logic [31:0] o_branch_target,
	output logic o_compact_state,
	output logic o_load_req,
	output logic [31:0] o_load_addr,
	output logic o_busy
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LOAD} state_e;

	// ==========================================================
	// Decode
	logic [3:0] dst_sel;
	logic [3:0] src_sel;
	op_e op;
	logic first_high_operand_flag;
	logic is_hireg;
	logic is_pcload;
	logic [2:0] ld_dst;
	logic [31:0] a_val;
	logic [31:0] b_val;
	logic [31:0] pc_read;
	logic [31:0] ld_base;
	logic [31:0] ld_off;
	logic [32:0] diff;
	state_e state_r;
	logic [1:0] wait_r;
	logic [2:0] ld_dst_r;

	hireg_field u_field (
		.i_instr(i_instr),
		.o_dst_sel(dst_sel),
		.o_src_sel(src_sel),
		.o_op(op),
		.o_first_high_operand_flag(first_high_operand_flag)
	);

	function automatic logic [31:0] operand(input logic [3:0] sel, input logic [31:0] rf,
		input logic [31:0] pc);
		operand = (sel == PC_REG) ? pc : rf;
	endfunction

	// Branch or PC write: both cost a refill
	function automatic logic writes_pc(input op_e code, input logic [3:0] dst);
		writes_pc = (code == OP_BRX) || (code != OP_CMP && dst == PC_REG);
	endfunction

	always_comb begin
		// Undefined encodings run as decoded; no trap is raised
		is_hireg = (i_instr[15:10] == FMT5_MATCH);
		is_pcload = (i_instr[15:11] == FMT6_MATCH);
		ld_dst = i_instr[LDR_RD_LSB +: 3];
		pc_read = (i_instr_addr + PC_AHEAD) & ~32'h0000_0001;
		ld_base = (i_instr_addr + PC_AHEAD) & ~32'h0000_0002;
		ld_off = {22'h0, i_instr[LDR_OFF_LSB +: 8], 2'h0};
		o_rd_a_sel = dst_sel;
		o_rd_b_sel = src_sel;
		a_val = operand(dst_sel, i_rd_a_data, pc_read);
		b_val = operand(src_sel, i_rd_b_data, pc_read);
		diff = {1'b0, a_val} - {1'b0, b_val};
	end

	// ==========================================================
	// Sequencer; stalls model the 32-bit-state cycle costs
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_r <= ST_IDLE;
			wait_r <= 2'h0;
			ld_dst_r <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (i_issue && is_pcload) begin
						state_r <= ST_LOAD;
						wait_r <= 2'(LDR_CYCLES - 1);
						ld_dst_r <= ld_dst;
					end else if (i_issue && is_hireg && writes_pc(op, dst_sel)) begin
						state_r <= ST_WAIT;
						wait_r <= 2'(PCW_CYCLES - 1);
					end
				end
				ST_WAIT: begin
					wait_r <= wait_r - 2'h1;
					if (wait_r == 2'h1)
						state_r <= ST_IDLE;
				end
				// Data may return late; wait_r floors at zero
				ST_LOAD: begin
					if (wait_r != 2'h0)
						wait_r <= wait_r - 2'h1;
					if (i_load_valid && wait_r <= 2'h1)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Register write, flags, branch
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rf_wr <= '0;
			o_flags <= flags_s'(FLAGS_RST);
			o_flags_we <= 1'b0;
			o_branch <= 1'b0;
			o_branch_target <= 32'h0;
			o_compact_state <= COMPACT_RST;
		end else begin
			o_rf_wr.en <= 1'b0;
			o_flags_we <= 1'b0;
			o_branch <= 1'b0;
			if (state_r == ST_IDLE && i_issue && is_hireg) begin
				case (op)
					// A PC destination also redirects fetch
					OP_ADD: begin
						o_rf_wr <= '{addr: dst_sel, data: a_val + b_val, en: 1'b1};
						o_branch <= (dst_sel == PC_REG);
						o_branch_target <= a_val + b_val;
					end
					OP_CMP: begin
						// Sole flag writer in this format
						o_flags.n <= diff[31];
						o_flags.z <= (diff[31:0] == 32'h0);
						o_flags.c <= ~diff[32];
						o_flags.v <= (a_val[31] ^ b_val[31]) & (a_val[31] ^ diff[31]);
						o_flags_we <= 1'b1;
					end
					OP_MOV: begin
						o_rf_wr <= '{addr: dst_sel, data: b_val, en: 1'b1};
						o_branch <= (dst_sel == PC_REG);
						o_branch_target <= b_val;
					end
					OP_BRX: begin
						// Target from source select only
						o_branch <= 1'b1;
						o_branch_target <= {b_val[31:1], 1'b0};
						o_compact_state <= b_val[0];
					end
					default: o_branch <= 1'b0;
				endcase
			// Early data is not taken; the load cost must elapse first
			end else if (state_r == ST_LOAD && i_load_valid && wait_r <= 2'h1) begin
				o_rf_wr <= '{addr: {1'b0, ld_dst_r}, data: i_load_data, en: 1'b1};
			end
		end
	end

	// ==========================================================
	// Load request
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_load_req <= 1'b0;
			o_load_addr <= 32'h0;
		end else begin
			o_load_req <= 1'b0;
			if (state_r == ST_IDLE && i_issue && is_pcload) begin
				o_load_req <= 1'b1;
				o_load_addr <= ld_base + ld_off;
			end
		end
	end

	// ==========================================================
	// Issue hold-off
	// Mirrors the sequencer's next state so no issue slot is lost
	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			o_busy <= 1'b0;
		else
			o_busy <= (state_r != ST_IDLE) ? !(state_r == ST_WAIT && wait_r == 2'h1) &&
				!(state_r == ST_LOAD && i_load_valid && wait_r <= 2'h1) :
				(i_issue && (is_pcload || (is_hireg && writes_pc(op, dst_sel))));
	end
endmodule
`default_nettype wire

// File: hireg_chk_asserts.sv
// Purpose: port checks of the high-register decoder
// Assumes: one clock, synchronous reset
// Notes: branch state not checked for a r15 source
`timescale 1ns/1ps
`default_nettype none
module hireg_chk
	import hireg_pkg::*;
(
	// Watched ports
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_issue,
	input wire logic [15:0] i_instr,
	input wire logic [31:0] i_instr_addr,
	input wire logic [31:0] i_rd_b_data,
	input wire logic [3:0] o_rd_a_sel,
	input wire logic [3:0] o_rd_b_sel,
	input wire rf_wr_s o_rf_wr,
	input wire logic o_flags_we,
	input wire logic o_branch,
	input wire logic o_compact_state,
	input wire logic o_load_req,
	input wire logic [31:0] o_load_addr,
	input wire logic o_busy
);
	// ====
	// Taken requests
	logic f5, go, go6;
	logic [1:0] op;
	logic [3:0] sa, sb;
	logic [31:0] la;
	assign f5 = i_instr[15:10] == 6'h11;
	assign go = i_issue && !o_busy && f5;
	assign go6 = i_issue && !o_busy && i_instr[15:11] == 5'h09;
	assign op = i_instr[9:8];
	assign sa = {i_instr[7], i_instr[2:0]};
	assign sb = {i_instr[6], i_instr[5:3]};
	assign la = ((i_instr_addr + 32'h4) & ~32'h2) + {22'h0, i_instr[7:0], 2'h0};
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// Branch refill holds issue off for two cycles
	sequence s_pcw;
		o_busy [*2] ##1 !o_busy;
	endsequence
	AST_SEL_A: assert property (f5 |-> o_rd_a_sel == sa)
		else $error("dest select");
	AST_SEL_B: assert property (f5 |-> o_rd_b_sel == sb)
		else $error("src select");
	AST_CMP: assert property (go && op == 2'h1 |=> o_flags_we && !o_rf_wr.en)
		else $error("compare result");
	AST_NOFLAG: assert property (go && op != 2'h1 |=> !o_flags_we)
		else $error("flags touched");
	AST_WR: assert property (go && !op[0] |=> o_rf_wr.en && o_rf_wr.addr == $past(sa))
		else $error("write back");
	AST_BX: assert property (go && op == 2'h3 && sb != 4'hf |=>
		o_branch && o_compact_state == $past(i_rd_b_data[0])) else $error("branch");
	AST_BUSY: assert property (go && op == 2'h3 |=> s_pcw)
		else $error("branch cycles");
	AST_LDR: assert property (go6 |=> o_load_req && o_load_addr == $past(la))
		else $error("load address");
endmodule
bind hireg_ops_branch_pc_load_decode hireg_chk u_chk (.*);
`default_nettype wire

// File: tb.sv
// Purpose: random and corner tests of the high-register decoder
// Assumes: bench serves register reads
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hireg_pkg::*;
	// ====
	// Ports and bench state
	logic i_sys_clk = 1'h0, i_srst = 1'h1, i_issue = 1'h0, i_load_valid = 1'h0;
	logic [15:0] i_instr = 16'h0;
	logic [31:0] i_instr_addr = 32'h0, i_load_data = 32'h0;
	logic [31:0] i_rd_a_data, i_rd_b_data, o_branch_target, o_load_addr, ra, rb, e;
	logic [3:0] o_rd_a_sel, o_rd_b_sel, d, s;
	logic [1:0] h;
	logic [31:0] rf [16];
	rf_wr_s o_rf_wr;
	flags_s o_flags;
	logic o_flags_we, o_branch, o_compact_state, o_load_req, o_busy;
	int fail_count = 0, n_tests = 0, op;
	hireg_ops_branch_pc_load_decode u_dut (.*);
	always #25 i_sys_clk = ~i_sys_clk;
	function automatic logic [31:0] rd(input logic [3:0] r);
		return r == 4'hf ? (i_instr_addr + 32'h4) & ~32'h1 : rf[r];
	endfunction
	always_comb begin
		i_rd_a_data = rd(o_rd_a_sel);
		i_rd_b_data = rd(o_rd_b_sel);
	end
	task automatic chk(input logic [31:0] g, x);
		n_tests++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, g, x);
		end
	endtask
	task automatic report_and_stop;
		$display("tests %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#(50 * 2000);
		fail_count++;
		report_and_stop;
	end
	// ====
	// Main sequence, first three passes are corners
	initial begin
		void'($urandom(32'h5796));
		foreach (rf[k]) rf[k] = $urandom;
		repeat (2) @(negedge i_sys_clk);
		i_srst = 1'h0;
		for (int i = 0; i < 80; i++) begin
			op = i < 2 ? 2 + 2 * i : i == 2 ? 0 : $urandom % 5;
			h = op == 3 ? {1'h0, 1'($urandom)} : 2'(1 + $urandom % 3);
			if (i == 0) h = 2'h1;
			if (i == 2) h = 2'h2;
			d = {h[1] && op < 3, 3'($urandom)};
			if (i == 2) d = 4'hf;
			s = i == 0 ? 4'hf : {h[0], 3'($urandom)};
			if (op == 3 && s == 4'hf) s = 4'he;
			i_instr_addr = $urandom & ~32'h1;
			i_instr = op == 4 ? {5'h09, d[2:0], i == 1 ? 8'hff : 8'($urandom)}
				: {6'h11, 2'(op), h, s[2:0], d[2:0]};
			i_issue = 1'h1;
			ra = rd(d);
			rb = rd(s);
			e = ra - rb;
			@(negedge i_sys_clk);
			case (op)
			0, 2: begin
				e = op ? rb : ra + rb;
				chk(o_rf_wr.en, 1);
				chk(o_rf_wr.addr, d);
				chk(o_rf_wr.data, e);
				chk(o_branch, d == 4'hf);
				chk(o_busy, d == 4'hf);
				rf[d] = e;
			end
			1: begin
				chk(o_flags_we, 1);
				chk(o_rf_wr.en, 0);
				chk(o_flags[3:2], {e[31], e == 32'h0});
				chk(o_flags[1:0], {ra >= rb, (ra[31] ^ rb[31]) & (e[31] ^ ra[31])});
			end
			3: begin
				chk(o_branch_target, rb & ~32'h1);
				chk(o_compact_state, rb[0]);
			end
			default: begin
				e = ((i_instr_addr + 32'h4) & ~32'h2) + 32'(i_instr[7:0]) * 4;
				chk(o_load_addr, e);
				@(negedge i_sys_clk);
				i_load_valid = 1'h1;
				i_load_data = $urandom;
				@(negedge i_sys_clk);
				i_load_valid = 1'h0;
				chk(o_rf_wr.en, 1);
				chk(o_rf_wr.addr, d);
				chk(o_rf_wr.data, i_load_data);
				rf[d] = i_load_data;
			end
			endcase
			for (int k = 0; k < 8 && o_busy; k++) @(negedge i_sys_clk);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
